// File: pkg/ivfs_pkg.sv
// Purpose: constants, types and helpers for the input voltage fault supervisor
// Assumes: 100 MHz clock, command codes used directly as register addresses
// Notes:   reset values of limits are plain defaults, not calibrated figures
package ivfs_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          UNIT_BASE_NS    = 10000;
  localparam int          UNIT_BASE_CYC   = (UNIT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  UNIT_BASE_LAST  = 10'(UNIT_BASE_CYC - 1);

  localparam logic [7:0]  CMD_CLEAR       = 8'h03;
  localparam logic [7:0]  CMD_OV_FAULT    = 8'h55;
  localparam logic [7:0]  CMD_OV_ACTION   = 8'h56;
  localparam logic [7:0]  CMD_OV_WARN     = 8'h57;
  localparam logic [7:0]  CMD_UV_WARN     = 8'h58;
  localparam logic [7:0]  CMD_UV_FAULT    = 8'h59;
  localparam logic [7:0]  CMD_UV_ACTION   = 8'h5a;
  localparam logic [7:0]  CMD_GOOD_ON     = 8'h5e;
  localparam logic [7:0]  CMD_GOOD_OFF    = 8'h5f;
  localparam logic [7:0]  CMD_TIME_UNIT   = 8'hd2;
  localparam logic [7:0]  CMD_SPECIAL     = 8'he0;

  localparam logic [15:0] RST_OV_FAULT    = 16'h03ff;
  localparam logic [15:0] RST_OV_WARN     = 16'h03ff;
  localparam logic [15:0] RST_UV_WARN     = 16'h0000;
  localparam logic [15:0] RST_UV_FAULT    = 16'h0000;
  localparam logic [7:0]  RST_ACTION      = 8'h80;
  localparam logic [15:0] RST_GOOD_ON     = 16'h4000;
  localparam logic [15:0] RST_GOOD_OFF    = 16'h3800;
  localparam logic [15:0] RST_TIME_UNIT   = 16'h0000;
  localparam logic [7:0]  RST_SPECIAL     = 8'h00;

  localparam int          RESP_HI         = 7;
  localparam int          RESP_LO         = 6;
  localparam int          RETRY_HI        = 5;
  localparam int          RETRY_LO        = 3;
  localparam int          DELAY_HI        = 2;
  localparam int          DELAY_LO        = 0;
  localparam int          RATIO_REG_EN_BIT = 0;
  localparam int          LIN_EXP_LO      = 11;
  localparam logic [5:0]  LIN_EXP_BIAS    = 6'h10;

  localparam logic [1:0]  RESP_IGNORE     = 2'h0;
  localparam logic [1:0]  RESP_RUN_ON     = 2'h1;
  localparam logic [1:0]  RESP_DISABLE    = 2'h2;
  localparam logic [1:0]  RESP_RESUME     = 2'h3;
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;

  typedef enum logic [4:0] {
    CH_RUN    = 5'h01,
    CH_HOLD   = 5'h02,
    CH_RETRY  = 5'h04,
    CH_LATCH  = 5'h08,
    CH_RESUME = 5'h10
  } ivfs_chan_state_t;

  // linear 11 to fixed point, 16 fractional bits, so limits and input compare directly
  function automatic logic signed [47:0] ivfs_lin_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic        [5:0]  sh;
    m = 48'(signed'(v[LIN_EXP_LO-1:0]));
    sh = 6'(signed'(v[15:LIN_EXP_LO])) + LIN_EXP_BIAS;
    ivfs_lin_fix = m <<< sh;
  endfunction
endpackage

// File: rtl/ivfs_fault_chan.sv
// Purpose: programmable response to one input voltage fault
// Assumes: unit_tick_i is a one-cycle pulse per delay time unit
// Notes:   disable_o is registered; clear_i overrides every state
`timescale 1ns/100ps
module ivfs_fault_chan
  import ivfs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       fault_i,
  input  wire logic [7:0] action_i,
  input  wire logic       unit_tick_i,
  input  wire logic       clear_i,
  output logic            disable_o
);
  ivfs_chan_state_t st_r;
  ivfs_chan_state_t st_nxt;
  logic [7:0]       cnt_r;
  logic [7:0]       cnt_nxt;
  logic [2:0]       left_r;
  logic [2:0]       left_nxt;

  wire  [1:0] resp_w   = action_i[RESP_HI:RESP_LO];
  wire  [2:0] retry_w  = action_i[RETRY_HI:RETRY_LO];
  wire  [7:0] last_w   = (8'h01 << action_i[DELAY_HI:DELAY_LO]) - 8'h01;
  wire        expire_w = unit_tick_i && (cnt_r == last_w);
  wire        more_w   = (retry_w == RETRY_FOREVER) || (left_r > 3'h1);
  // clear restarts from run; a fault in the same cycle still wins
  ivfs_chan_state_t st_eff;
  assign st_eff = clear_i ? CH_RUN : st_r;

  always_comb begin
    st_nxt = st_eff;
    cnt_nxt = unit_tick_i ? cnt_r + 8'h01 : cnt_r;
    left_nxt = left_r;
    case (st_eff)
      CH_RUN: begin
        cnt_nxt = 8'h00;
        left_nxt = retry_w;
        if (fault_i) begin
          case (resp_w)
            RESP_RUN_ON: st_nxt = CH_HOLD;
            RESP_DISABLE: st_nxt = (retry_w == RETRY_NONE) ? CH_LATCH : CH_RETRY;
            RESP_RESUME: st_nxt = CH_RESUME;
            default: st_nxt = CH_RUN;
          endcase
        end
      end
      CH_HOLD: begin
        if (!fault_i) begin
          st_nxt = CH_RUN;
        end else if (expire_w) begin
          cnt_nxt = 8'h00;
          st_nxt = (retry_w == RETRY_NONE) ? CH_LATCH : CH_RETRY;
        end
      end
      CH_RETRY: begin
        if (expire_w) begin
          cnt_nxt = 8'h00;
          if (!fault_i) begin
            st_nxt = CH_RUN;
          end else if (more_w) begin
            left_nxt = left_r - 3'h1;
          end else begin
            st_nxt = CH_LATCH;
          end
        end
      end
      CH_RESUME: if (!fault_i) st_nxt = CH_RUN;
      CH_LATCH: st_nxt = CH_LATCH;
      default: st_nxt = CH_RUN;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= CH_RUN;
      cnt_r <= 8'h00;
      left_r <= RETRY_NONE;
      disable_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt;
      disable_o <= (st_nxt == CH_RETRY) || (st_nxt == CH_LATCH) || (st_nxt == CH_RESUME);
    end
  end

  property p_ignore;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_r == CH_RUN && fault_i && resp_w == RESP_IGNORE && !clear_i) |=> !disable_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault disabled output");

  property p_disable_now;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_r == CH_RUN && fault_i && resp_w == RESP_DISABLE && !clear_i) |=> disable_o;
  endproperty
  a_disable_now: assert property (p_disable_now) else $error("disable response late");

  property p_latch_holds;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_r == CH_LATCH && !clear_i) |=> disable_o && st_r == CH_LATCH;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched fault released");

  property p_resume;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_r == CH_RESUME && resp_w == RESP_RESUME) |=> (disable_o == $past(fault_i));
  endproperty
  a_resume: assert property (p_resume) else $error("resume response wrong");
endmodule

// File: rtl/ivfs_top.sv
// Purpose: input voltage supervision, fault response and output good control
// Assumes: vin_i linear 11, vout_i unsigned exponent -11, both clk_i synchronous
// Notes:   command port is the already decoded PMBus transaction
`timescale 1ns/100ps
module ivfs_top
  import ivfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_word_i,
  input  wire logic [7:0]  reg_cmd_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        enable_i,
  input  wire logic [15:0] vin_i,
  input  wire logic [15:0] vout_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_ack_o,
  output logic             out_enable_o,
  output logic             output_good_signal_o,
  output logic             ov_fault_o,
  output logic             ov_warn_o,
  output logic             uv_fault_o,
  output logic             uv_warn_o,
  output logic             hybrid_ratio_regulation_o
);
  logic [15:0] ov_fault_thr_r;
  logic [7:0]  ov_action_r;
  logic [15:0] ov_warn_thr_r;
  logic [15:0] uv_warn_thr_r;
  logic [15:0] uv_fault_thr_r;
  logic [7:0]  uv_action_r;
  logic [15:0] good_on_thr_r;
  logic [15:0] good_off_thr_r;
  logic [15:0] time_unit_r;
  logic [7:0]  special_r;
  logic [9:0]  base_cnt_r;
  logic [15:0] unit_cnt_r;
  logic        unit_tick_r;
  logic        enable_d_r;
  logic        ov_disable;
  logic        uv_disable;

  // word writes reach limits and time unit, byte writes reach actions and special options
  wire wr_word_w   = reg_wr_i && reg_word_i;
  wire wr_byte_w   = reg_wr_i && !reg_word_i;
  wire we_ovf_w    = wr_word_w && (reg_cmd_i == CMD_OV_FAULT);
  wire we_ova_w    = wr_byte_w && (reg_cmd_i == CMD_OV_ACTION);
  wire we_ovw_w    = wr_word_w && (reg_cmd_i == CMD_OV_WARN);
  wire we_uvw_w    = wr_word_w && (reg_cmd_i == CMD_UV_WARN);
  wire we_uvf_w    = wr_word_w && (reg_cmd_i == CMD_UV_FAULT);
  wire we_uva_w    = wr_byte_w && (reg_cmd_i == CMD_UV_ACTION);
  wire we_gon_w    = wr_word_w && (reg_cmd_i == CMD_GOOD_ON);
  wire we_goff_w   = wr_word_w && (reg_cmd_i == CMD_GOOD_OFF);
  wire we_unit_w   = wr_word_w && (reg_cmd_i == CMD_TIME_UNIT);
  wire we_spec_w   = wr_byte_w && (reg_cmd_i == CMD_SPECIAL);
  // send byte style command, data and size ignored
  wire clear_cmd_w = reg_wr_i && (reg_cmd_i == CMD_CLEAR);
  wire clear_w     = clear_cmd_w || (enable_i && !enable_d_r);

  wire [15:0] rd_data_w =
    (reg_cmd_i == CMD_OV_FAULT)  ? ov_fault_thr_r :
    (reg_cmd_i == CMD_OV_ACTION) ? {8'h00, ov_action_r} :
    (reg_cmd_i == CMD_OV_WARN)   ? ov_warn_thr_r :
    (reg_cmd_i == CMD_UV_WARN)   ? uv_warn_thr_r :
    (reg_cmd_i == CMD_UV_FAULT)  ? uv_fault_thr_r :
    (reg_cmd_i == CMD_UV_ACTION) ? {8'h00, uv_action_r} :
    (reg_cmd_i == CMD_GOOD_ON)   ? good_on_thr_r :
    (reg_cmd_i == CMD_GOOD_OFF)  ? good_off_thr_r :
    (reg_cmd_i == CMD_TIME_UNIT) ? time_unit_r :
    (reg_cmd_i == CMD_SPECIAL)   ? {8'h00, special_r} :
                                   16'h0000;

  // decoded to fixed point so mixed exponents compare correctly
  wire signed [47:0] vin_fix_w   = ivfs_lin_fix(vin_i);
  wire ov_fault_w  = vin_fix_w > ivfs_lin_fix(ov_fault_thr_r);
  wire ov_warn_w   = vin_fix_w > ivfs_lin_fix(ov_warn_thr_r);
  wire uv_below_w  = vin_fix_w < ivfs_lin_fix(uv_warn_thr_r);
  wire uv_fault_w  = vin_fix_w < ivfs_lin_fix(uv_fault_thr_r);
  wire ratio_reg_w = special_r[RATIO_REG_EN_BIT] && uv_below_w;
  wire out_en_w    = enable_i && !ov_disable && !uv_disable;
  wire good_lvl_w  = (vout_i >= good_on_thr_r);
  wire good_set_w  = out_en_w && good_lvl_w;
  wire good_drop_w = !out_en_w || (vout_i <= good_off_thr_r);
  wire good_nxt_w  = good_drop_w ? 1'b0 : (good_set_w || output_good_signal_o);

  wire base_end_w  = (base_cnt_r == UNIT_BASE_LAST);
  wire unit_end_w  = base_end_w && (unit_cnt_r == time_unit_r);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ov_fault_thr_r <= RST_OV_FAULT;
      ov_warn_thr_r <= RST_OV_WARN;
      uv_warn_thr_r <= RST_UV_WARN;
      uv_fault_thr_r <= RST_UV_FAULT;
    end else begin
      if (we_ovf_w) ov_fault_thr_r <= reg_wdata_i;
      if (we_ovw_w) ov_warn_thr_r <= reg_wdata_i;
      if (we_uvw_w) uv_warn_thr_r <= reg_wdata_i;
      if (we_uvf_w) uv_fault_thr_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ov_action_r <= RST_ACTION;
      uv_action_r <= RST_ACTION;
      special_r <= RST_SPECIAL;
      time_unit_r <= RST_TIME_UNIT;
    end else begin
      if (we_ova_w) ov_action_r <= reg_wdata_i[7:0];
      if (we_uva_w) uv_action_r <= reg_wdata_i[7:0];
      if (we_spec_w) special_r <= reg_wdata_i[7:0];
      if (we_unit_w) time_unit_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      good_on_thr_r <= RST_GOOD_ON;
      good_off_thr_r <= RST_GOOD_OFF;
    end else begin
      if (we_gon_w) good_on_thr_r <= reg_wdata_i;
      if (we_goff_w) good_off_thr_r <= reg_wdata_i;
    end
  end

  // read answer one cycle after the request; writes are acknowledged too
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_rd_i || reg_wr_i;
      if (reg_rd_i) reg_rdata_o <= rd_data_w;
    end
  end

  // two stage divider: fixed base period, then register value plus one bases per unit
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      base_cnt_r <= 10'h000;
      unit_cnt_r <= 16'h0000;
      unit_tick_r <= 1'b0;
    end else begin
      base_cnt_r <= base_end_w ? 10'h000 : base_cnt_r + 10'h001;
      if (unit_end_w) unit_cnt_r <= 16'h0000;
      else if (base_end_w) unit_cnt_r <= unit_cnt_r + 16'h0001;
      unit_tick_r <= unit_end_w;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      enable_d_r <= 1'b0;
      ov_fault_o <= 1'b0;
      ov_warn_o <= 1'b0;
      uv_fault_o <= 1'b0;
      uv_warn_o <= 1'b0;
      hybrid_ratio_regulation_o <= 1'b0;
    end else begin
      enable_d_r <= enable_i;
      ov_fault_o <= ov_fault_w;
      ov_warn_o <= ov_warn_w;
      uv_fault_o <= uv_fault_w;
      uv_warn_o <= uv_below_w;
      hybrid_ratio_regulation_o <= ratio_reg_w;
    end
  end

  ivfs_fault_chan u_ov_chan (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .fault_i     (ov_fault_o),
    .action_i    (ov_action_r),
    .unit_tick_i (unit_tick_r),
    .clear_i     (clear_w),
    .disable_o   (ov_disable)
  );

  ivfs_fault_chan u_uv_chan (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .fault_i     (uv_fault_o),
    .action_i    (uv_action_r),
    .unit_tick_i (unit_tick_r),
    .clear_i     (clear_w),
    .disable_o   (uv_disable)
  );

  // output good follows the gated enable, so it drops with any fault shutdown
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_enable_o <= 1'b0;
      output_good_signal_o <= 1'b0;
    end else begin
      out_enable_o <= out_en_w;
      output_good_signal_o <= good_nxt_w;
    end
  end

  property p_ov_fault;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ivfs_lin_fix(vin_i) > ivfs_lin_fix(ov_fault_thr_r)) |=> ov_fault_o;
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("over-voltage fault missed");

  property p_uv_fault;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(uv_fault_o) |-> $past(uv_fault_w);
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("under-voltage fault without cause");

  property p_ov_warn;
    @(posedge clk_i) disable iff (sys_rst_i)
    ov_warn_o |-> $past(ov_warn_w);
  endproperty
  a_ov_warn: assert property (p_ov_warn) else $error("warning without cause");

  property p_ratio_gate;
    @(posedge clk_i) disable iff (sys_rst_i)
    hybrid_ratio_regulation_o |-> $past(special_r[RATIO_REG_EN_BIT]) && uv_warn_o;
  endproperty
  a_ratio_gate: assert property (p_ratio_gate) else $error("regulation active while disabled");

  property p_good_on;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(output_good_signal_o) |-> $past(good_lvl_w) && out_enable_o;
  endproperty
  a_good_on: assert property (p_good_on) else $error("output good rose below threshold");

  property p_good_off;
    @(posedge clk_i) disable iff (sys_rst_i)
    (vout_i <= good_off_thr_r) |=> !output_good_signal_o;
  endproperty
  a_good_off: assert property (p_good_off) else $error("output good held below off level");

  property p_read_back;
    @(posedge clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_cmd_i == CMD_OV_FAULT && !reg_wr_i) |=> reg_ack_o && (reg_rdata_o == ov_fault_thr_r);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read did not return limit");

  property p_clear_cmd;
    @(posedge clk_i) disable iff (sys_rst_i)
    (clear_cmd_w && !ov_fault_o && !uv_fault_o && enable_i) |=> ##1 out_enable_o;
  endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("clear did not restore output");

  property p_unit_len;
    @(posedge clk_i) disable iff (sys_rst_i)
    (unit_tick_r && time_unit_r == 16'h0000 && !we_unit_w) |-> ##1 !unit_tick_r [*8];
  endproperty
  a_unit_len: assert property (p_unit_len) else $error("time unit too short");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i || reg_rd_i) |=> reg_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("request not acknowledged");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

  property p_ov_action_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
    we_ova_w |=> ov_action_r == 8'($past(reg_wdata_i));
  endproperty
  a_ov_action_wr: assert property (p_ov_action_wr) else $error("over-voltage action not stored");

  property p_uv_action_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
    we_uva_w |=> uv_action_r == 8'($past(reg_wdata_i));
  endproperty
  a_uv_action_wr: assert property (p_uv_action_wr) else $error("under-voltage action not stored");

  property p_byte_refused;
    @(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_word_i && reg_cmd_i == CMD_OV_ACTION) |=> $stable(ov_action_r);
  endproperty
  a_byte_refused: assert property (p_byte_refused) else $error("word write changed action byte");

  property p_word_refused;
    @(posedge clk_i) disable iff (sys_rst_i)
    (reg_wr_i && !reg_word_i && reg_cmd_i == CMD_OV_FAULT) |=> $stable(ov_fault_thr_r);
  endproperty
  a_word_refused: assert property (p_word_refused) else $error("byte write changed limit");

  property p_ov_warn_set;
    @(posedge clk_i) disable iff (sys_rst_i)
    (vin_fix_w > ivfs_lin_fix(ov_warn_thr_r)) |=> ov_warn_o;
  endproperty
  a_ov_warn_set: assert property (p_ov_warn_set) else $error("over-voltage warning missed");

  property p_uv_warn_set;
    @(posedge clk_i) disable iff (sys_rst_i)
    (vin_fix_w < ivfs_lin_fix(uv_warn_thr_r)) |=> uv_warn_o;
  endproperty
  a_uv_warn_set: assert property (p_uv_warn_set) else $error("under-voltage warning missed");

  property p_uv_fault_set;
    @(posedge clk_i) disable iff (sys_rst_i)
    (vin_fix_w < ivfs_lin_fix(uv_fault_thr_r)) |=> uv_fault_o;
  endproperty
  a_uv_fault_set: assert property (p_uv_fault_set) else $error("under-voltage fault missed");

  property p_out_gate;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ov_disable || uv_disable) |=> !out_enable_o;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output on while a channel disables it");

  property p_good_needs_en;
    @(posedge clk_i) disable iff (sys_rst_i)
    output_good_signal_o |-> out_enable_o;
  endproperty
  a_good_needs_en: assert property (p_good_needs_en) else $error("output good with output off");

  property p_tick_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
    unit_tick_r |=> !unit_tick_r;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("unit tick longer than one cycle");
endmodule

// File: test/ivfs_host_model.sv
// Purpose: host model issuing command port transfers
// Assumes: one transfer in flight, ack one cycle after the request
// Notes:   released command and data lines show inverted values
`timescale 1ns/100ps
module ivfs_host_model (
  input  wire logic        clk_i,
  input  wire logic        reg_ack_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic             reg_word_o,
  output logic [7:0]       reg_cmd_o,
  output logic [15:0]      reg_wdata_o,
  output logic             late_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_word_o = 1'b0;
    reg_cmd_o = 8'h00;
    reg_wdata_o = 16'h0000;
    late_o = 1'b0;
  end

  task automatic xfer(input logic wr, input logic word, input logic [7:0] cmd,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    @(negedge clk_i);
    reg_wr_o = wr;
    reg_rd_o = ~wr;
    reg_word_o = word;
    reg_cmd_o = cmd;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines must not look valid
    reg_cmd_o = ~cmd;
    reg_wdata_o = ~d;
    n = 0;
    while (reg_ack_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    late_o = (reg_ack_i !== 1'b1);
    q = reg_rdata_i;
  endtask
endmodule

// File: test/ivfs_tb_top.sv
// Purpose: self-checking bench for the input voltage fault supervisor
// Assumes: time unit register left at its reset value unless noted
// Notes:   delay checks leave slack for a free-running unit tick
`timescale 1ns/100ps
module ivfs_tb_top;
  logic        clk_i = 1'b0;
  logic        sys_rst_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic        reg_word_i;
  logic [7:0]  reg_cmd_i;
  logic [15:0] reg_wdata_i;
  logic        enable_i;
  logic [15:0] vin_i;
  logic [15:0] vout_i;
  logic [15:0] reg_rdata_o;
  logic        reg_ack_o;
  logic        out_enable_o;
  logic        good_o;
  logic [3:0]  flags;
  logic        ratio_o;
  logic        late;
  int          err_count = 0;
  int          num_checks = 0;
  logic [7:0]  cmds [8] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h5f};
  logic [15:0] dflt [8] = '{16'h03ff, 16'h0080, 16'h03ff, 16'h0000, 16'h0000, 16'h0080, 16'h4000, 16'h3800};
  logic [15:0] nval [8] = '{16'h0064, 16'h0080, 16'h005a, 16'h002c, 16'h0028, 16'h0080, 16'h6000, 16'h5800};
  logic [15:0] vins [7] = '{16'h0030, 16'h005a, 16'h005b, 16'h0065, 16'h0064, 16'h002a, 16'h0027};
  logic [3:0]  flgs [7] = '{4'h0, 4'h0, 4'h2, 4'h3, 4'h2, 4'h8, 4'hc};
  logic [15:0] vouts [5] = '{16'h6000, 16'h5c00, 16'h5800, 16'h5c00, 16'h6000};
  logic        goods [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int          ro [3][4] = '{'{0, 'h41, 950, 2100}, '{0, 'h42, 2950, 4100}, '{1, 'h41, 1950, 4100}};

  always #5 clk_i = ~clk_i;

  ivfs_host_model u_host (
    .clk_i       (clk_i),
    .reg_ack_i   (reg_ack_o),
    .reg_rdata_i (reg_rdata_o),
    .reg_wr_o    (reg_wr_i),
    .reg_rd_o    (reg_rd_i),
    .reg_word_o  (reg_word_i),
    .reg_cmd_o   (reg_cmd_i),
    .reg_wdata_o (reg_wdata_i),
    .late_o      (late)
  );

  ivfs_top u_dut (
    .clk_i                     (clk_i),
    .sys_rst_i                 (sys_rst_i),
    .reg_wr_i                  (reg_wr_i),
    .reg_rd_i                  (reg_rd_i),
    .reg_word_i                (reg_word_i),
    .reg_cmd_i                 (reg_cmd_i),
    .reg_wdata_i               (reg_wdata_i),
    .enable_i                  (enable_i),
    .vin_i                     (vin_i),
    .vout_i                    (vout_i),
    .reg_rdata_o               (reg_rdata_o),
    .reg_ack_o                 (reg_ack_o),
    .out_enable_o              (out_enable_o),
    .output_good_signal_o      (good_o),
    .ov_fault_o                (flags[0]),
    .ov_warn_o                 (flags[1]),
    .uv_fault_o                (flags[2]),
    .uv_warn_o                 (flags[3]),
    .hybrid_ratio_regulation_o (ratio_o)
  );

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chkb(input string nm, input logic seen, input logic exp);
    chk(nm, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d);
    logic [15:0] q;
    u_host.xfer(1'b1, w, c, d, q);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] q;
    u_host.xfer(1'b0, 1'b1, c, 16'h0000, q);
    chkb("ack", late, 1'b0);
    chk("rdata", q, e);
  endtask

  // input change to output change takes three edges
  task automatic set_in(input logic [15:0] vi, input logic [15:0] vo);
    @(negedge clk_i);
    vin_i = vi;
    vout_i = vo;
    step(5);
  endtask

  initial begin
    step(40000);
    err_count++;
    stop_test();
  end

  initial begin
    sys_rst_i = 1'b1;
    enable_i = 1'b0;
    vin_i = 16'h0030;
    vout_i = 16'h0000;
    step(6);
    sys_rst_i = 1'b0;
    enable_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(cmds[i], dflt[i]);
      wr(cmds[i], !(i == 1 || i == 5), nval[i]);
      rd(cmds[i], nval[i]);
    end
    // wrong size and unmapped places
    wr(8'h56, 1'b1, 16'h00c0);
    rd(8'h56, 16'h0080);
    wr(8'h55, 1'b0, 16'h0070);
    rd(8'h55, 16'h0064);
    rd(8'h40, 16'h0000);
    wr(8'h56, 1'b0, 16'h0000);
    wr(8'h5a, 1'b0, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      set_in(vins[i], 16'h0000);
      chk("flags", {12'h000, flags}, {12'h000, flgs[i]});
      chkb("out_enable", out_enable_o, 1'b1);
    end
    set_in(16'h0030, 16'h0000);
    wr(8'h56, 1'b0, 16'h0080);
    set_in(16'h0065, 16'h0000);
    chkb("out_enable", out_enable_o, 1'b0);
    set_in(16'h0030, 16'h0000);
    step(1500);
    chkb("out_enable", out_enable_o, 1'b0);
    wr(8'h03, 1'b0, 16'h0000);
    step(5);
    chkb("out_enable", out_enable_o, 1'b1);
    set_in(16'h0065, 16'h0000);
    set_in(16'h0030, 16'h0000);
    enable_i = 1'b0;
    step(5);
    enable_i = 1'b1;
    step(5);
    chkb("out_enable", out_enable_o, 1'b1);
    wr(8'h56, 1'b0, 16'h00c0);
    set_in(16'h0065, 16'h0000);
    chkb("out_enable", out_enable_o, 1'b0);
    set_in(16'h0030, 16'h0000);
    chkb("out_enable", out_enable_o, 1'b1);
    // retry once; fault gone before the attempt
    wr(8'h56, 1'b0, 16'h0088);
    set_in(16'h0065, 16'h0000);
    chkb("out_enable", out_enable_o, 1'b0);
    set_in(16'h0030, 16'h0000);
    step(1200);
    chkb("out_enable", out_enable_o, 1'b1);
    // one attempt used up while the fault stays: latched
    set_in(16'h0065, 16'h0000);
    step(2100);
    set_in(16'h0030, 16'h0000);
    step(1200);
    chkb("out_enable", out_enable_o, 1'b0);
    wr(8'h03, 1'b0, 16'h0000);
    // run-on: delay code and time unit scale it
    for (int i = 0; i < 3; i++) begin
      wr(8'hd2, 1'b1, 16'(ro[i][0]));
      wr(8'h56, 1'b0, 16'(ro[i][1]));
      set_in(16'h0065, 16'h0000);
      step(ro[i][2]);
      chkb("out_enable", out_enable_o, 1'b1);
      step(ro[i][3] - ro[i][2]);
      chkb("out_enable", out_enable_o, 1'b0);
      set_in(16'h0030, 16'h0000);
      wr(8'h03, 1'b0, 16'h0000);
    end
    wr(8'h5a, 1'b0, 16'h00c0);
    set_in(16'h0027, 16'h0000);
    chkb("out_enable", out_enable_o, 1'b0);
    set_in(16'h0030, 16'h0000);
    chkb("out_enable", out_enable_o, 1'b1);
    for (int i = 0; i < 5; i++) begin
      set_in(16'h0030, vouts[i]);
      chkb("output_good", good_o, goods[i]);
    end
    set_in(16'h002a, 16'h6000);
    chkb("ratio_reg", ratio_o, 1'b0);
    wr(8'he0, 1'b0, 16'h0001);
    step(3);
    chkb("ratio_reg", ratio_o, 1'b1);
    set_in(16'h0030, 16'h6000);
    chkb("ratio_reg", ratio_o, 1'b0);
    stop_test();
  end
endmodule
